// File: xcr_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - slave port 0 read/write errors latch into status bits 5, 6; write 1 clears
// - slave port 1 read/write errors latch into status bits 13, 14; write 1 clears
// - master read, write, time-out errors latch into bits 19, 20, 21
// - bus request errors of both slaves and master show read-only at 4, 12, 18
// - queue errors of both slaves and master show read-only at 7, 15, 24
// - slave 1 config/command and master config errors show read-only at 11, 17
// - crossbar master-path and memory-path queue faults show read-only at 25, 26
// - a mask bit of 0 stops that status source from raising the interrupt
// - mask resets from its tie-off attribute, all implemented bits 1 by default
// - priorities count only in fixed and round-robin modes; 4 highest, 0 lowest
// - 3-bit priorities at 9:11, 13:15, 17:19, 21:23, 25:27 with set defaults
// - mode bits 30:31: 00 LRU, 01 round-robin, 10 fixed, 11 forbidden
// - master-path bit 29 enables the sync transfer attribute
// - memory-path arbiter has own register and tie-off; bits 28:29 reserved
// - queue status bits 28 to 31 flag over/underflow; write 1 clears each
// - any set queue fault bit raises that path's crossbar status bit
// - writing 1 to bit 30 or 31 resets read or write command queue
// - queue reset bits always read back as zero
// - status bits set even while their mask bit is 0
// - write 1 clears clear-on-write bits; read-only bits follow their source
module xcr_regs #(
  parameter logic [31:0] mask_tieoff_attr       = xcr_pkg::MASK_RST,
  parameter logic [31:0] master_arb_tieoff_attr = xcr_pkg::ARB_RST,
  parameter logic [31:0] memory_arb_tieoff_attr = xcr_pkg::ARB_RST
) (
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      resetn_i,
  // control register bus
  input  wire logic [xcr_pkg::ABUS_W-1:0] dcr_abus_i,
  input  wire logic                      dcr_read_i,
  input  wire logic                      dcr_write_i,
  input  wire logic [31:0]               dcr_wdata_i,
  output logic      [31:0]               dcr_rdata_o,
  output logic                           dcr_ack_o,
  // slave port 0 sources
  input  wire logic                      s0_cfg_err_i,
  input  wire logic                      s0_mirq_i,
  input  wire logic                      s0_read_error_i,
  input  wire logic                      s0_write_error_i,
  input  wire logic                      s0_fifo_err_i,
  // slave port 1 sources
  input  wire logic                      s1_cfg_err_i,
  input  wire logic                      s1_mirq_i,
  input  wire logic                      s1_read_error_i,
  input  wire logic                      s1_write_error_i,
  input  wire logic                      s1_fifo_err_i,
  // master port sources
  input  wire logic                      m_cfg_err_i,
  input  wire logic                      m_mirq_i,
  input  wire logic                      m_read_error_i,
  input  wire logic                      m_write_error_i,
  input  wire logic                      m_timeout_i,
  input  wire logic                      m_fifo_err_i,
  // crossbar queues, index 0 master path, 1 memory path
  input  wire logic [1:0][3:0]           queue_fault_i,
  output logic      [1:0]                read_cmd_queue_reset_o,
  output logic      [1:0]                write_cmd_queue_reset_o,
  // arbiter configuration
  output logic      [1:0][2:0]           instr_read_priority_o,
  output logic      [1:0][2:0]           data_write_priority_o,
  output logic      [1:0][2:0]           data_read_priority_o,
  output logic      [1:0][2:0]           slave_port_1_priority_o,
  output logic      [1:0][2:0]           slave_port_0_priority_o,
  output logic      [1:0][1:0]           arb_mode_o,
  output logic      [1:0]                prio_active_o,
  output logic                           sync_attr_enable_o,
  // interrupt
  output logic                           irq_o
);

  logic        ack_r;
  logic [31:0] rdata_r;
  logic [31:0] w1c_r;
  logic [31:0] mask_r;
  logic [31:0] arb_r  [2];
  logic [3:0]  fifo_r [2];
  logic [1:0]  qrst_r [2];

  wire         rd_go = dcr_read_i && !ack_r;
  wire         wr_go = dcr_write_i && !ack_r;
  wire         ist_wr  = wr_go && (dcr_abus_i == xcr_pkg::ADDR_IST);
  wire         mask_wr = wr_go && (dcr_abus_i == xcr_pkg::ADDR_MASK);

  // event sources of the clear-on-write bits
  logic [31:0] w1c_set;
  logic [31:0] ro_w;
  logic [31:0] ist_w;
  always_comb begin
    w1c_set = 32'h0;
    w1c_set[xcr_pkg::IST_S0_RD] = s0_read_error_i;
    w1c_set[xcr_pkg::IST_S0_WR] = s0_write_error_i;
    w1c_set[xcr_pkg::IST_S1_RD] = s1_read_error_i;
    w1c_set[xcr_pkg::IST_S1_WR] = s1_write_error_i;
    w1c_set[xcr_pkg::IST_M_RD]  = m_read_error_i;
    w1c_set[xcr_pkg::IST_M_WR]  = m_write_error_i;
    w1c_set[xcr_pkg::IST_M_TOUT] = m_timeout_i;
    ro_w = 32'h0;
    ro_w[xcr_pkg::IST_S0_CFG]  = s0_cfg_err_i;
    ro_w[xcr_pkg::IST_S0_MIRQ] = s0_mirq_i;
    ro_w[xcr_pkg::IST_S1_MIRQ] = s1_mirq_i;
    ro_w[xcr_pkg::IST_M_MIRQ]  = m_mirq_i;
    ro_w[xcr_pkg::IST_S0_FIFO] = s0_fifo_err_i;
    ro_w[xcr_pkg::IST_S1_FIFO] = s1_fifo_err_i;
    ro_w[xcr_pkg::IST_M_FIFO]  = m_fifo_err_i;
    ro_w[xcr_pkg::IST_S1_CFG]  = s1_cfg_err_i;
    ro_w[xcr_pkg::IST_M_CFG]   = m_cfg_err_i;
    ro_w[xcr_pkg::IST_XM_FIFO] = |fifo_r[0];
    ro_w[xcr_pkg::IST_XC_FIFO] = |fifo_r[1];
    ist_w = w1c_r | ro_w;
  end

  // set wins over a clear in the same cycle; mask has no say here
  wire [31:0] w1c_clr = ist_wr ? dcr_wdata_i : 32'h0;
  wire [31:0] w1c_nxt = ((w1c_r & ~w1c_clr) | w1c_set) & xcr_pkg::IST_W1C_BITS;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      w1c_r  <= 32'h0;
      mask_r <= mask_tieoff_attr & xcr_pkg::IST_IMPL;
    end else begin
      w1c_r <= w1c_nxt;
      if (mask_wr) begin
        mask_r <= dcr_wdata_i & xcr_pkg::IST_IMPL;
      end
    end
  end

  assign irq_o = |(ist_w & mask_r);

  // per path arbiter config, queue fault status, queue resets
  for (genvar p = 0; p < 2; p++) begin : g_path
    localparam logic [31:0] ARB_INIT = (p == 0) ? master_arb_tieoff_attr
                                                : memory_arb_tieoff_attr;
    wire       arb_wr  = wr_go && (dcr_abus_i == xcr_pkg::ARB_ADDR[p]);
    wire       fifo_wr = wr_go && (dcr_abus_i == xcr_pkg::FIFO_ADDR[p]);
    wire       misc_wr = wr_go && (dcr_abus_i == xcr_pkg::MISC_ADDR[p]);
    wire [3:0] fifo_clr = fifo_wr ? dcr_wdata_i[3:0] : 4'h0;
    wire [3:0] fifo_nxt = ((fifo_r[p] & ~fifo_clr) | queue_fault_i[p]) & xcr_pkg::FIFO_MASK;
    wire [1:0] qrst_nxt = misc_wr ? dcr_wdata_i[1:0] : 2'h0;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        arb_r[p]  <= ARB_INIT & xcr_pkg::ARB_WMASK[p];
        fifo_r[p] <= 4'h0;
        qrst_r[p] <= 2'h0;
      end else begin
        if (arb_wr) begin
          arb_r[p] <= dcr_wdata_i & xcr_pkg::ARB_WMASK[p];
        end
        fifo_r[p] <= fifo_nxt;
        qrst_r[p] <= qrst_nxt;
      end
    end

    assign read_cmd_queue_reset_o[p]  = qrst_r[p][xcr_pkg::MISC_RRST];
    assign write_cmd_queue_reset_o[p] = qrst_r[p][xcr_pkg::MISC_WRST];
    assign instr_read_priority_o[p]   = arb_r[p][xcr_pkg::ARB_IR_LSB +: 3];
    assign data_write_priority_o[p]   = arb_r[p][xcr_pkg::ARB_DW_LSB +: 3];
    assign data_read_priority_o[p]    = arb_r[p][xcr_pkg::ARB_DR_LSB +: 3];
    assign slave_port_1_priority_o[p] = arb_r[p][xcr_pkg::ARB_S1_LSB +: 3];
    assign slave_port_0_priority_o[p] = arb_r[p][xcr_pkg::ARB_S0_LSB +: 3];
    assign arb_mode_o[p]              = arb_r[p][xcr_pkg::ARB_MODE_LSB +: 2];
    assign prio_active_o[p] = (arb_mode_o[p] == xcr_pkg::MODE_RR) ||
                              (arb_mode_o[p] == xcr_pkg::MODE_FIXED);
  end

  assign sync_attr_enable_o = arb_r[0][xcr_pkg::ARB_SYNC_BIT];

  // read mux; queue reset registers always read zero, unmapped reads zero
  wire [31:0] rd_mux =
    (dcr_abus_i == xcr_pkg::ADDR_IST)   ? ist_w :
    (dcr_abus_i == xcr_pkg::ADDR_MASK)  ? mask_r :
    (dcr_abus_i == xcr_pkg::ADDR_MARB)  ? arb_r[0] :
    (dcr_abus_i == xcr_pkg::ADDR_MFIFO) ? {28'h0, fifo_r[0]} :
    (dcr_abus_i == xcr_pkg::ADDR_XARB)  ? arb_r[1] :
    (dcr_abus_i == xcr_pkg::ADDR_XFIFO) ? {28'h0, fifo_r[1]} :
    32'h0;

  // one-cycle acknowledge after a request, then a gap cycle
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= rd_go || wr_go;
      if (rd_go) begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign dcr_ack_o   = ack_r;
  assign dcr_rdata_o = rdata_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_rrst_write;
    wr_go && (dcr_abus_i == xcr_pkg::ADDR_MMISC) && dcr_wdata_i[xcr_pkg::MISC_RRST];
  endsequence
  sequence s_rrst_pulse;
    read_cmd_queue_reset_o[0] ##1 !read_cmd_queue_reset_o[0];
  endsequence
  sequence s_fault_in;
    queue_fault_i[1][3] && !(wr_go && dcr_abus_i == xcr_pkg::ADDR_XFIFO);
  endsequence

  chk_s0_read_latch: assert property (s0_read_error_i |=> w1c_r[xcr_pkg::IST_S0_RD])
    else $error("slave 0 read error not latched");
  chk_s1_write_latch: assert property (s1_write_error_i |=> w1c_r[xcr_pkg::IST_S1_WR])
    else $error("slave 1 write error not latched");
  chk_timeout_sticky: assert property (
    w1c_r[xcr_pkg::IST_M_TOUT] && !ist_wr |=> w1c_r[xcr_pkg::IST_M_TOUT])
    else $error("time-out flag lost without a clear");
  chk_clear_on_write: assert property (
    ist_wr && dcr_wdata_i[xcr_pkg::IST_M_RD] && !m_read_error_i |=>
    !w1c_r[xcr_pkg::IST_M_RD])
    else $error("write of one did not clear status");
  chk_masked_silent: assert property (
    (mask_r & ist_w) == 32'h0 |-> !irq_o)
    else $error("interrupt raised while all sources masked");
  chk_mirq_irq: assert property (
    m_mirq_i && mask_r[xcr_pkg::IST_M_MIRQ] |-> irq_o)
    else $error("unmasked master request error gave no interrupt");
  chk_queue_fault: assert property (
    s_fault_in |=> fifo_r[1][3] && irq_o == |(ist_w & mask_r) && ist_w[xcr_pkg::IST_XC_FIFO])
    else $error("queue fault not flagged in both registers");
  chk_rrst_pulse: assert property (s_rrst_write |=> s_rrst_pulse)
    else $error("read queue reset not a single pulse");
  chk_misc_zero: assert property (
    rd_go && dcr_abus_i == xcr_pkg::ADDR_XMISC |=> dcr_ack_o && dcr_rdata_o == 32'h0)
    else $error("queue reset register read non-zero");
  chk_reserved_arb: assert property (arb_r[1][3:2] == 2'h0)
    else $error("memory path reserved bits set");
  chk_ack_once: assert property ((rd_go || wr_go) |=> dcr_ack_o ##1 !dcr_ack_o)
    else $error("acknowledge not a single pulse");

endmodule // xcr_regs

// File: xcr_pkg.sv
package xcr_pkg;
  // control register bus
  localparam int          ABUS_W     = 10;
  localparam logic [9:0]  ADDR_IST   = 10'h020;
  localparam logic [9:0]  ADDR_MASK  = 10'h021;
  localparam logic [9:0]  ADDR_MARB  = 10'h023;
  localparam logic [9:0]  ADDR_MFIFO = 10'h024;
  localparam logic [9:0]  ADDR_MMISC = 10'h026;
  localparam logic [9:0]  ADDR_XARB  = 10'h028;
  localparam logic [9:0]  ADDR_XFIFO = 10'h029;
  localparam logic [9:0]  ADDR_XMISC = 10'h02B;
  // per path addresses, index 0 master-bus path, 1 memory-controller path
  localparam logic [1:0][9:0] ARB_ADDR  = {ADDR_XARB, ADDR_MARB};
  localparam logic [1:0][9:0] FIFO_ADDR = {ADDR_XFIFO, ADDR_MFIFO};
  localparam logic [1:0][9:0] MISC_ADDR = {ADDR_XMISC, ADDR_MMISC};
  // interrupt status bit positions (lsb numbering, msb is bit 0 in print)
  localparam int IST_S0_CFG  = 28;
  localparam int IST_S0_MIRQ = 27;
  localparam int IST_S0_RD   = 26;
  localparam int IST_S0_WR   = 25;
  localparam int IST_S0_FIFO = 24;
  localparam int IST_S1_CFG  = 20;
  localparam int IST_S1_MIRQ = 19;
  localparam int IST_S1_RD   = 18;
  localparam int IST_S1_WR   = 17;
  localparam int IST_S1_FIFO = 16;
  localparam int IST_M_CFG   = 14;
  localparam int IST_M_MIRQ  = 13;
  localparam int IST_M_RD    = 12;
  localparam int IST_M_WR    = 11;
  localparam int IST_M_TOUT  = 10;
  localparam int IST_M_FIFO  = 7;
  localparam int IST_XM_FIFO = 6;
  localparam int IST_XC_FIFO = 5;
  localparam logic [31:0] IST_W1C_BITS = 32'h06061C00;
  localparam logic [31:0] IST_IMPL     = 32'h1F1F7CE0;
  localparam logic [31:0] MASK_RST     = 32'h1F1F7CE0;
  // arbitration config fields
  localparam int ARB_IR_LSB   = 20;
  localparam int ARB_DW_LSB   = 16;
  localparam int ARB_DR_LSB   = 12;
  localparam int ARB_S1_LSB   = 8;
  localparam int ARB_S0_LSB   = 4;
  localparam int ARB_SYNC_BIT = 2;
  localparam int ARB_MODE_LSB = 0;
  localparam logic [31:0] ARB_RST    = 32'h00432010;
  localparam logic [1:0][31:0] ARB_WMASK = {32'h00777773, 32'h00777777};
  // arbitration modes
  localparam logic [1:0] MODE_LRU   = 2'h0;
  localparam logic [1:0] MODE_RR    = 2'h1;
  localparam logic [1:0] MODE_FIXED = 2'h2;
  // queue fault status and queue reset controls
  localparam logic [3:0] FIFO_MASK    = 4'hF;
  localparam int         MISC_RRST    = 1;
  localparam int         MISC_WRST    = 0;
endpackage

// File: xcr_sw_model.sv
`timescale 1ns/1ns
module xcr_sw_model (
  // clock
  input  wire logic        core_clk_i,
  // register bus answer
  input  wire logic [31:0] dcr_rdata_i,
  input  wire logic        dcr_ack_i,
  // register bus request
  output logic      [9:0]  dcr_abus_o,
  output logic             dcr_read_o,
  output logic             dcr_write_o,
  output logic      [31:0] dcr_wdata_o
);
  initial begin
    dcr_abus_o = 10'h3FF;
    dcr_read_o = 1'b0;
    dcr_write_o = 1'b0;
    dcr_wdata_o = 32'hA5A5A5A5;
  end
  // one word a request; lines inverted once released so stale values never match
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(negedge core_clk_i);
    dcr_abus_o = a;
    dcr_wdata_o = d;
    dcr_read_o = !w;
    dcr_write_o = w;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge core_clk_i);
      ok = (dcr_ack_i === 1'b1);
    end
    q = dcr_rdata_i;
    dcr_read_o = 1'b0;
    dcr_write_o = 1'b0;
    dcr_abus_o = ~a;
    dcr_wdata_o = ~d;
  endtask
endmodule // xcr_sw_model

// File: crossbar_irq_arbiter_config_regs_tb.sv
`timescale 1ns/1ns
module crossbar_irq_arbiter_config_regs_tb;
  typedef struct packed {
    logic        wr;
    logic [9:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } xcr_row_t;
  logic            core_clk_i, resetn_i, dcr_read_i, dcr_write_i, dcr_ack_o, irq_o;
  logic            sync_attr_enable_o;
  logic [9:0]      dcr_abus_i;
  logic [31:0]     dcr_wdata_i, dcr_rdata_o, q, pcnt;
  logic [1:0]      read_cmd_queue_reset_o, write_cmd_queue_reset_o, prio_active_o;
  logic [1:0][1:0] arb_mode_o;
  logic [1:0][2:0] instr_read_priority_o, data_write_priority_o, data_read_priority_o;
  logic [1:0][2:0] slave_port_1_priority_o, slave_port_0_priority_o;
  logic [1:0][3:0] queue_fault_i;
  logic [6:0]      ev;
  logic [8:0]      lv;
  wire             s0_read_error_i, s0_write_error_i, s1_read_error_i, s1_write_error_i;
  wire             m_read_error_i, m_write_error_i, m_timeout_i, m_cfg_err_i, m_mirq_i;
  wire             s0_cfg_err_i, s0_mirq_i, s0_fifo_err_i, s1_cfg_err_i, s1_mirq_i;
  wire             s1_fifo_err_i, m_fifo_err_i;
  int              err_count = 0;
  int              total_checks = 0;
  int              epos [7] = '{31-5, 31-6, 31-13, 31-14, 31-19, 31-20, 31-21};
  // distinct priorities within 0..4, mode never 11
  xcr_row_t rows [11] = '{
    '{1'b0, xcr_pkg::ADDR_MASK, 32'h0, 32'h1F1F7CE0},
    '{1'b0, xcr_pkg::ADDR_MARB, 32'h0, 32'h00432010},
    '{1'b0, xcr_pkg::ADDR_XARB, 32'h0, 32'h00432010},
    '{1'b0, xcr_pkg::ADDR_MFIFO, 32'h0, 32'h0},
    '{1'b1, xcr_pkg::ADDR_MARB, 32'hFFCB9A8E, 32'h00431206},
    '{1'b1, xcr_pkg::ADDR_XARB, 32'hFFCB9A8E, 32'h00431202},
    '{1'b1, xcr_pkg::ADDR_MMISC, 32'h3, 32'h0},
    '{1'b1, xcr_pkg::ADDR_XMISC, 32'h3, 32'h0},
    '{1'b1, 10'h022, 32'hFFFFFFFF, 32'h0},
    '{1'b1, xcr_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h1F1F7CE0},
    '{1'b1, xcr_pkg::ADDR_IST, 32'hFFFFFFFF, 32'h0}};
  assign {s0_read_error_i, s0_write_error_i, s1_read_error_i, s1_write_error_i,
          m_read_error_i, m_write_error_i, m_timeout_i} = ev;
  assign {s0_cfg_err_i, s0_mirq_i, s0_fifo_err_i, s1_cfg_err_i, s1_mirq_i,
          s1_fifo_err_i, m_cfg_err_i, m_mirq_i, m_fifo_err_i} = lv;
  xcr_regs u_dut (
    .core_clk_i, .resetn_i, .dcr_abus_i, .dcr_read_i, .dcr_write_i, .dcr_wdata_i,
    .dcr_rdata_o, .dcr_ack_o, .s0_cfg_err_i, .s0_mirq_i, .s0_read_error_i,
    .s0_write_error_i, .s0_fifo_err_i, .s1_cfg_err_i, .s1_mirq_i, .s1_read_error_i,
    .s1_write_error_i, .s1_fifo_err_i, .m_cfg_err_i, .m_mirq_i, .m_read_error_i,
    .m_write_error_i, .m_timeout_i, .m_fifo_err_i, .queue_fault_i,
    .read_cmd_queue_reset_o, .write_cmd_queue_reset_o, .instr_read_priority_o,
    .data_write_priority_o, .data_read_priority_o, .slave_port_1_priority_o,
    .slave_port_0_priority_o, .arb_mode_o, .prio_active_o, .sync_attr_enable_o, .irq_o);
  xcr_sw_model u_sw (
    .core_clk_i, .dcr_rdata_i(dcr_rdata_o), .dcr_ack_i(dcr_ack_o),
    .dcr_abus_o(dcr_abus_i), .dcr_read_o(dcr_read_i), .dcr_write_o(dcr_write_i),
    .dcr_wdata_o(dcr_wdata_i));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // weighted so a stretched or misrouted queue reset pulse changes the sum
  initial pcnt = 32'h0;
  always @(posedge core_clk_i) pcnt <= pcnt + {28'h0, write_cmd_queue_reset_o,
                                               read_cmd_queue_reset_o};
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
    logic ok;
    u_sw.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t no acknowledge", $time);
      results();
    end
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(q, e, "read value");
  endtask
  task automatic fire(input logic [6:0] v);
    @(negedge core_clk_i);
    ev = v;
    @(negedge core_clk_i);
    ev = 7'h0;
  endtask
  initial begin
    resetn_i = 1'b0;
    ev = 7'h0;
    lv = 9'h0;
    queue_fault_i = '0;
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk(irq_o, 1'b0, "irq after reset");
    foreach (rows[i]) begin
      if (rows[i].wr) acc(1'b1, rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    chk(pcnt, 32'hF, "queue reset pulses");
    chk(sync_attr_enable_o, 1'b1, "sync enable");
    for (int m = 0; m < 3; m++) begin
      acc(1'b1, xcr_pkg::ADDR_MARB, 32'h00012340 | 32'(m));
      chk(arb_mode_o[0], 32'(m), "mode");
      chk(prio_active_o[0], 32'(m != 0), "priority use");
      chk(slave_port_0_priority_o[0], 32'h4, "priority field");
      chk(slave_port_1_priority_o[0], 32'h3, "slave 1 priority");
      chk(data_read_priority_o[0], 32'h2, "data read priority");
      chk(data_write_priority_o[0], 32'h1, "data write priority");
      chk(instr_read_priority_o[0], 32'h0, "instr read priority");
    end
    for (int i = 0; i < 7; i++) begin
      fire(7'h40 >> i);
      chk(irq_o, 1'b1, "irq on event");
      rdchk(xcr_pkg::ADDR_IST, 32'h1 << epos[i]);
      acc(1'b1, xcr_pkg::ADDR_IST, 32'h1 << epos[i]);
      rdchk(xcr_pkg::ADDR_IST, 32'h0);
    end
    acc(1'b1, xcr_pkg::ADDR_MASK, 32'h0);
    fire(7'h01);
    chk(irq_o, 1'b0, "masked irq");
    rdchk(xcr_pkg::ADDR_IST, 32'h1 << (31 - 21));
    acc(1'b1, xcr_pkg::ADDR_MASK, 32'h1 << (31 - 21));
    chk(irq_o, 1'b1, "unmasked irq");
    acc(1'b1, xcr_pkg::ADDR_IST, 32'hFFFFFFFF);
    chk(irq_o, 1'b0, "cleared irq");
    lv = 9'h1FF;
    rdchk(xcr_pkg::ADDR_IST, 32'h19196080);
    acc(1'b1, xcr_pkg::ADDR_IST, 32'hFFFFFFFF);
    rdchk(xcr_pkg::ADDR_IST, 32'h19196080);
    lv = 9'h0;
    rdchk(xcr_pkg::ADDR_IST, 32'h0);
    @(negedge core_clk_i);
    queue_fault_i = {4'h9, 4'h8};
    @(negedge core_clk_i);
    queue_fault_i = '0;
    rdchk(xcr_pkg::ADDR_MFIFO, 32'h8);
    rdchk(xcr_pkg::ADDR_XFIFO, 32'h9);
    rdchk(xcr_pkg::ADDR_IST, 32'h60);
    acc(1'b1, xcr_pkg::ADDR_MFIFO, 32'h8);
    rdchk(xcr_pkg::ADDR_MFIFO, 32'h0);
    rdchk(xcr_pkg::ADDR_IST, 32'h20);
    acc(1'b1, xcr_pkg::ADDR_MMISC, 32'h2);
    @(negedge core_clk_i);
    chk(pcnt, 32'h10, "read queue reset");
    @(negedge core_clk_i);
    resetn_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
    resetn_i = 1'b1;
    rdchk(xcr_pkg::ADDR_XFIFO, 32'h0);
    rdchk(xcr_pkg::ADDR_MARB, 32'h00432010);
    rdchk(xcr_pkg::ADDR_MASK, 32'h1F1F7CE0);
    results();
  end
endmodule // crossbar_irq_arbiter_config_regs_tb
